//--- design/scmc_pkg.sv
// constants, types and helpers shared by the system clock mode control block
package scmc_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int HS_2M_HZ = 2_000_000;
  localparam int HS_4M_HZ = 4_000_000;
  localparam int HS_8M_HZ = 8_000_000;
  localparam int LS_HZ = 32_000;
  localparam logic [8:0] HS_PER_2M = 9'(CLK_HZ / HS_2M_HZ);
  localparam logic [8:0] HS_PER_4M = 9'(CLK_HZ / HS_4M_HZ);
  localparam logic [8:0] HS_PER_8M = 9'(CLK_HZ / HS_8M_HZ);
  localparam logic [8:0] LS_PER = 9'(CLK_HZ / LS_HZ);
  localparam int HS_START_NS = 16_000;
  localparam int LS_START_NS = 100_000;
  localparam int HS_START_CYC = (HS_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int LS_START_CYC = (LS_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ************************************************************
  // register map and fields
  // ************************************************************
  localparam logic [7:0] ADDR_SCC = 8'h00;
  localparam logic [7:0] ADDR_HSC = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam int SCC_SEL_LSB = 5;
  localparam int SCC_HSIDLE_BIT = 1;
  localparam int SCC_LSIDLE_BIT = 0;
  localparam int HSC_FREQ_LSB = 2;
  localparam int HSC_STABLE_BIT = 1;
  localparam int HSC_ON_BIT = 0;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_CUR_LSB = 4;
  localparam int STAT_LSOK_BIT = 8;
  localparam int STAT_PEND_BIT = 9;
  localparam logic [2:0] SCC_SEL_RST = 3'h7;
  localparam logic SCC_IDLE_RST = 1'b0;
  localparam logic [1:0] HSC_FREQ_RST = 2'h0;
  localparam logic HSC_ON_RST = 1'b0;
  localparam logic [2:0] SEL_SUB = 3'h7;

  typedef enum logic [2:0] {
    MODE_FAST, MODE_SLOW, MODE_SLEEP, MODE_IDLE_LOW_ONLY, MODE_IDLE_BOTH_OSC, MODE_IDLE_HIGH_ONLY
  } scmc_mode_t;

  // low bits of the high tick counter that must be all ones for one divided pulse
  function automatic logic [5:0] ratio_mask(input logic [2:0] sel);
    ratio_mask = 6'((7'h01 << sel) - 7'h01);
  endfunction

  function automatic logic [8:0] hs_period(input logic [1:0] freq);
    unique case (freq)
      2'h1: hs_period = HS_PER_4M;
      2'h2: hs_period = HS_PER_8M;
      default: hs_period = HS_PER_2M;
    endcase
  endfunction

endpackage

//--- design/scmc_osc_if.sv
// oscillator control and status bundle between the control logic and an rc oscillator
`timescale 1ns/10ps
interface scmc_osc_if;
  logic on;
  logic restart;
  logic [8:0] period;
  logic tick;
  logic stable;
  modport osc (input on, input restart, input period, output tick, output stable);
  modport ctl (output on, output restart, output period, input tick, input stable);
endinterface

//--- design/scmc_rc_osc.sv
// rc oscillator stand-in: start-up delay, stable flag and a tick enable at its rate
`timescale 1ns/10ps
module scmc_rc_osc #(
  parameter int START_CYC = 16
) (
  input wire logic clk,
  input wire logic reset,
  scmc_osc_if.osc osc
);
  logic [11:0] startCnt_r;
  logic stable_r;
  logic [8:0] per_r;
  logic [8:0] perCnt_r;
  logic tick_r;

  // ************************************************************
  // start-up; the period is latched here so a new rate waits for stable
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      startCnt_r <= 12'h000;
      stable_r <= 1'b0;
      per_r <= 9'h001;
    end else if (!osc.on || osc.restart) begin
      startCnt_r <= 12'h000;
      stable_r <= 1'b0;
      per_r <= osc.period;
    end else if (!stable_r) begin
      // the rate register settles in the same edge as the restart, so keep following it
      per_r <= osc.period;
      if (startCnt_r == 12'(START_CYC - 1)) begin
        stable_r <= 1'b1;
      end
      startCnt_r <= startCnt_r + 12'h001;
    end
  end

  // ************************************************************
  // tick generation
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      perCnt_r <= 9'h000;
      tick_r <= 1'b0;
    end else if (!osc.on || !stable_r) begin
      perCnt_r <= 9'h000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (perCnt_r == per_r - 9'h001);
      perCnt_r <= (perCnt_r == per_r - 9'h001) ? 9'h000 : perCnt_r + 9'h001;
    end
  end

  assign osc.tick = tick_r;
  assign osc.stable = stable_r;
endmodule

//--- design/scmc_sys_div.sv
// system clock divider and source switch, changing only on a period boundary
`timescale 1ns/10ps
module scmc_sys_div
  import scmc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsTick,
  input wire logic subTick,
  input wire logic [2:0] reqSel,
  output logic [2:0] curSel,
  output logic sysTick
);
  logic [2:0] curSel_r;
  logic [5:0] cnt_r;
  logic sysTick_r;
  logic pulse;

  always_comb begin
    if (curSel_r == SEL_SUB) begin
      pulse = subTick;
    end else begin
      pulse = hsTick && ((cnt_r & ratio_mask(curSel_r)) == ratio_mask(curSel_r));
    end
  end

  // a stopped source freezes the switch too; the controller keeps the old one running in fast and slow mode, and when halted only if its idle bit is set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      curSel_r <= SCC_SEL_RST;
      cnt_r <= 6'h00;
      sysTick_r <= 1'b0;
    end else begin
      sysTick_r <= pulse;
      if (pulse) begin
        curSel_r <= reqSel;
        cnt_r <= 6'h00;
      end else if (hsTick) begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end

  assign curSel = curSel_r;
  assign sysTick = sysTick_r;
endmodule

//--- design/scmc_top.sv
// system clock mode control: apb registers, operating modes and clock gating
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
module scmc_top
  import scmc_pkg::*;
#(
  parameter int HS_START = HS_START_CYC,
  parameter int LS_START = LS_START_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpuHalt,
  input wire logic wakeUp,
  input wire logic watchdogEn,
  output logic cpuClkEn,
  output logic sysClkEn,
  output logic highClkEn,
  output logic subClkEn,
  output logic lowOscClkEn,
  output logic hsOscRun,
  output logic lsOscRun,
  output logic [2:0] opMode
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [2:0] sysClkSel_r;
  logic hsIdleEn_r;
  logic lsIdleEn_r;
  logic [1:0] hsFreqSel_r;
  logic hsOscOnBit_r;
  logic [2:0] activeSel_r;
  scmc_mode_t mode_r;
  scmc_mode_t mode_nxt;
  logic [31:0] prdata_r;
  logic [2:0] curSel;
  logic sysTick;
  logic running;
  logic hsNeeded;
  logic subRun;
  logic setupPh;
  logic accessPh;
  logic wrScc;
  logic wrHsc;
  logic hsRestart;

  scmc_osc_if hsIf();
  scmc_osc_if lsIf();

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ADDR_SCC) || (a == ADDR_HSC) || (a == ADDR_STAT);
  endfunction

  // ************************************************************
  // apb slave
  // ************************************************************
  assign setupPh = psel && !penable;
  assign accessPh = psel && penable;
  assign wrScc = accessPh && pwrite && (paddr == ADDR_SCC);
  assign wrHsc = accessPh && pwrite && (paddr == ADDR_HSC);
  assign pready = 1'b1;
  // the status word is read only, so writing it is flagged like a hole in the map
  assign pslverr = accessPh && (!addr_mapped(paddr) || (pwrite && paddr == ADDR_STAT));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupPh && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      unique case (paddr)
        ADDR_SCC: begin
          prdata_r[SCC_SEL_LSB +: 3] <= sysClkSel_r;
          prdata_r[SCC_HSIDLE_BIT] <= hsIdleEn_r;
          prdata_r[SCC_LSIDLE_BIT] <= lsIdleEn_r;
        end
        ADDR_HSC: begin
          prdata_r[HSC_FREQ_LSB +: 2] <= hsFreqSel_r;
          prdata_r[HSC_STABLE_BIT] <= hsIf.stable;
          prdata_r[HSC_ON_BIT] <= hsOscOnBit_r;
        end
        ADDR_STAT: begin
          prdata_r[STAT_MODE_LSB +: 3] <= mode_r;
          prdata_r[STAT_CUR_LSB +: 3] <= curSel;
          prdata_r[STAT_LSOK_BIT] <= lsIf.stable;
          prdata_r[STAT_PEND_BIT] <= (activeSel_r != sysClkSel_r) || (curSel != activeSel_r);
        end
        default: begin
          prdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign prdata = prdata_r;

  // ************************************************************
  // clock control register
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sysClkSel_r <= SCC_SEL_RST;
      hsIdleEn_r <= SCC_IDLE_RST;
      lsIdleEn_r <= SCC_IDLE_RST;
    end else if (wrScc) begin
      sysClkSel_r <= pwdata[SCC_SEL_LSB +: 3];
      hsIdleEn_r <= pwdata[SCC_HSIDLE_BIT];
      lsIdleEn_r <= pwdata[SCC_LSIDLE_BIT];
    end
  end

  // ************************************************************
  // fast oscillator control register
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hsFreqSel_r <= HSC_FREQ_RST;
      hsOscOnBit_r <= HSC_ON_RST;
    end else if (wrHsc) begin
      hsFreqSel_r <= pwdata[HSC_FREQ_LSB +: 2];
      hsOscOnBit_r <= pwdata[HSC_ON_BIT];
    end
  end

  // turning the oscillator on or retuning it drops the stable flag until it settles
  assign hsRestart = wrHsc && ((pwdata[HSC_ON_BIT] && !hsOscOnBit_r) ||
                               (pwdata[HSC_FREQ_LSB +: 2] != hsFreqSel_r));

  // ************************************************************
  // source handover: the new source must be stable first
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      activeSel_r <= SCC_SEL_RST;
    end else if (sysClkSel_r != activeSel_r) begin
      if (sysClkSel_r == SEL_SUB) begin
        if (lsIf.stable) begin
          activeSel_r <= SEL_SUB;
        end
      end else if (hsIf.stable) begin
        activeSel_r <= sysClkSel_r;
      end
    end
  end

  // ************************************************************
  // operating mode
  // ************************************************************
  assign running = (mode_r == MODE_FAST) || (mode_r == MODE_SLOW);

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_FAST, MODE_SLOW: begin
        if (cpuHalt) begin
          unique case ({hsIdleEn_r, lsIdleEn_r})
            2'b00: mode_nxt = MODE_SLEEP;
            2'b01: mode_nxt = MODE_IDLE_LOW_ONLY;
            2'b11: mode_nxt = MODE_IDLE_BOTH_OSC;
            2'b10: mode_nxt = MODE_IDLE_HIGH_ONLY;
          endcase
        end else begin
          mode_nxt = (curSel == SEL_SUB) ? MODE_SLOW : MODE_FAST;
        end
      end
      MODE_SLEEP, MODE_IDLE_LOW_ONLY, MODE_IDLE_BOTH_OSC, MODE_IDLE_HIGH_ONLY: begin
        if (wakeUp) begin
          mode_nxt = (curSel == SEL_SUB) ? MODE_SLOW : MODE_FAST;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r <= MODE_SLOW;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign opMode = mode_r;

  // ************************************************************
  // oscillators
  // ************************************************************
  // in fast and slow mode the outgoing high source stays on until the divider has left it, or the switch hangs
  assign hsNeeded = (curSel != SEL_SUB) || (activeSel_r != SEL_SUB) || (sysClkSel_r != SEL_SUB);

  always_comb begin
    if (running) begin
      hsIf.on = hsOscOnBit_r || hsNeeded;
    end else begin
      hsIf.on = hsIdleEn_r;
    end
  end

  assign hsIf.restart = hsRestart;
  assign hsIf.period = hs_period(hsFreqSel_r);
  // the raw slow oscillator only ever stops in sleep with the watchdog off
  assign lsIf.on = (mode_r != MODE_SLEEP) || watchdogEn;
  assign lsIf.restart = 1'b0;
  assign lsIf.period = LS_PER;

  scmc_rc_osc #(
    .START_CYC(HS_START)
  ) u_hs_osc (
    .clk(clk),
    .reset(reset),
    .osc(hsIf)
  );

  scmc_rc_osc #(
    .START_CYC(LS_START)
  ) u_ls_osc (
    .clk(clk),
    .reset(reset),
    .osc(lsIf)
  );

  // ************************************************************
  // clock gating
  // ************************************************************
  assign subRun = running || lsIdleEn_r;

  scmc_sys_div u_div (
    .clk(clk),
    .reset(reset),
    .hsTick(hsIf.tick),
    .subTick(lsIf.tick && subRun),
    .reqSel(activeSel_r),
    .curSel(curSel),
    .sysTick(sysTick)
  );

  assign sysClkEn = sysTick && (mode_r != MODE_SLEEP);
  assign cpuClkEn = sysTick && running;
  assign highClkEn = hsIf.tick;
  assign subClkEn = lsIf.tick && subRun;
  assign lowOscClkEn = lsIf.tick;
  assign hsOscRun = hsIf.on;
  assign lsOscRun = lsIf.on;

endmodule

//--- verification/scmc_top_properties.sv
// concurrent checks on the ports of the system clock mode control block
`timescale 1ns/10ps
module scmc_top_properties
  import scmc_pkg::*;
#(
  parameter int HS_START = 4,
  parameter int LS_START = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpuHalt,
  input wire logic wakeUp,
  input wire logic watchdogEn,
  input wire logic cpuClkEn,
  input wire logic sysClkEn,
  input wire logic highClkEn,
  input wire logic subClkEn,
  input wire logic lowOscClkEn,
  input wire logic hsOscRun,
  input wire logic lsOscRun,
  input wire logic [2:0] opMode
);
  // ************************************************
  // shadow of the control register and counters
  // ************************************************
  logic [2:0] sel_r;
  logic [1:0] idle_r;
  logic [9:0] hCnt_r;
  logic [9:0] settle_r;
  logic apbWr;
  logic [2:0] haltMode;
  assign apbWr = psel && penable && pwrite;
  assign haltMode = idle_r == 2'h0 ? MODE_SLEEP : idle_r == 2'h1 ? MODE_IDLE_LOW_ONLY :
                    idle_r == 2'h3 ? MODE_IDLE_BOTH_OSC : MODE_IDLE_HIGH_ONLY;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sel_r <= SCC_SEL_RST;
      idle_r <= 2'h0;
    end else if (apbWr && paddr == ADDR_SCC) begin
      sel_r <= pwdata[7:5];
      idle_r <= pwdata[1:0];
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hCnt_r <= 10'h000;
    end else if (sysClkEn) begin
      hCnt_r <= 10'h000;
    end else begin
      hCnt_r <= hCnt_r + {9'h000, highClkEn};
    end
  end
  // division is judged only once a ratio has had time to settle after any write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      settle_r <= 10'h000;
    end else if (apbWr || opMode != MODE_FAST) begin
      settle_r <= 10'h000;
    end else if (settle_r != 10'h3FF) begin
      settle_r <= settle_r + 10'h001;
    end
  end
  // ************************************************
  // properties
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_halt_enter;
    opMode <= MODE_SLOW && cpuHalt |=> opMode == $past(haltMode);
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt mode wrong");
  property p_halt_ignore;
    opMode >= MODE_SLEEP && !wakeUp |=> $stable(opMode);
  endproperty
  a_halt_ignore: assert property (p_halt_ignore) else $error("halted mode left");
  property p_cpu_off;
    opMode >= MODE_SLEEP |-> !cpuClkEn;
  endproperty
  a_cpu_off: assert property (p_cpu_off) else $error("cpu clock while halted");
  property p_sleep;
    opMode == MODE_SLEEP |-> !hsOscRun && !sysClkEn && !subClkEn && lsOscRun == watchdogEn;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep gating wrong");
  property p_idle_low;
    opMode == MODE_IDLE_LOW_ONLY |-> !hsOscRun && lsOscRun;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("low idle gating wrong");
  property p_idle_both;
    opMode == MODE_IDLE_BOTH_OSC |-> hsOscRun && lsOscRun;
  endproperty
  a_idle_both: assert property (p_idle_both) else $error("both idle gating wrong");
  property p_idle_high;
    opMode == MODE_IDLE_HIGH_ONLY |-> hsOscRun && !subClkEn;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("high idle gating wrong");
  property p_wake;
    opMode >= MODE_SLEEP && wakeUp |=>
      opMode == ($past(sel_r) == SEL_SUB ? MODE_SLOW : MODE_FAST);
  endproperty
  a_wake: assert property (p_wake) else $error("wake mode wrong");
  property p_rd_zero;
    psel && penable && !pwrite && paddr == ADDR_SCC |-> prdata[4:2] == 3'h0 && prdata[31:8] == 24'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unused bits read nonzero");
  property p_div;
    opMode == MODE_FAST && sysClkEn && settle_r == 10'h3FF |->
      hCnt_r + {9'h000, highClkEn} == (10'h001 << sel_r);
  endproperty
  a_div: assert property (p_div) else $error("divide ratio wrong");
  property p_low_osc_off;
    !lsOscRun |=> !lowOscClkEn;
  endproperty
  a_low_osc_off: assert property (p_low_osc_off) else $error("raw low clock while stopped");
  c_sleep_wd: cover property (opMode == MODE_SLEEP && watchdogEn);
  c_sleep_nowd: cover property (opMode == MODE_SLEEP && !lsOscRun);
  c_div64: cover property (opMode == MODE_FAST && sysClkEn && settle_r == 10'h3FF && sel_r == 3'h6);
  c_slverr: cover property (psel && penable && pslverr);
endmodule
bind scmc_top scmc_top_properties #(.HS_START(HS_START), .LS_START(LS_START)) chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuHalt(cpuHalt),
  .wakeUp(wakeUp), .watchdogEn(watchdogEn), .cpuClkEn(cpuClkEn), .sysClkEn(sysClkEn),
  .highClkEn(highClkEn), .subClkEn(subClkEn), .lowOscClkEn(lowOscClkEn),
  .hsOscRun(hsOscRun), .lsOscRun(lsOscRun), .opMode(opMode));

//--- verification/tb_system_clock_mode_control.sv
// self-checking bench for the system clock mode control block
`timescale 1ns/10ps
module tb_system_clock_mode_control;
  import scmc_pkg::*;
  // ************************************************
  // stimulus and design
  // ************************************************
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic cpuHalt = 1'b0;
  logic wakeUp = 1'b0;
  logic watchdogEn = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, cpuClkEn, sysClkEn, highClkEn, subClkEn, lowOscClkEn;
  logic hsOscRun, lsOscRun;
  logic [2:0] opMode;
  logic [32:0] busQ[$];
  logic [2:0] modeQ[$];
  logic [2:0] tbMode = 3'h1;
  logic [2:0] prevMode;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'hC0AB;
  always #50 clk = ~clk;
  // small start-up counts keep the run short
  scmc_top #(.HS_START(4), .LS_START(8)) dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuHalt(cpuHalt),
    .wakeUp(wakeUp), .watchdogEn(watchdogEn), .cpuClkEn(cpuClkEn), .sysClkEn(sysClkEn),
    .highClkEn(highClkEn), .subClkEn(subClkEn), .lowOscClkEn(lowOscClkEn),
    .hsOscRun(hsOscRun), .lsOscRun(lsOscRun), .opMode(opMode));
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // expected answer is queued before the request goes out
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    busQ.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic expect_mode(input logic [2:0] m);
    if (m !== tbMode) begin
      modeQ.push_back(m);
      tbMode = m;
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [2:0] halt_mode(input logic [1:0] idle);
    case (idle)
      2'h0: halt_mode = MODE_SLEEP;
      2'h1: halt_mode = MODE_IDLE_LOW_ONLY;
      2'h3: halt_mode = MODE_IDLE_BOTH_OSC;
      default: halt_mode = MODE_IDLE_HIGH_ONLY;
    endcase
  endfunction
  // ************************************************
  // monitors
  // ************************************************
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      check("apb", {pslverr, pwrite ? 32'h0 : prdata}, busQ.pop_front());
    end
    if (!reset && opMode !== prevMode) begin
      check("mode", {30'h0, opMode}, {30'h0, modeQ.pop_front()});
    end
    prevMode = opMode;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end
  // ************************************************
  // scenarios
  // ************************************************
  initial begin
    logic [2:0] sel;
    logic [1:0] idle;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, ADDR_SCC, 32'h0, {1'b0, 32'hE0});
    apb(1'b0, ADDR_HSC, 32'h0, 33'h0);
    apb(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0});
    apb(1'b1, ADDR_STAT, 32'hFF, {1'b1, 32'h0});
    apb(1'b1, ADDR_SCC, 32'hFF, 33'h0);
    apb(1'b0, ADDR_SCC, 32'h0, {1'b0, 32'hE3});
    apb(1'b1, ADDR_HSC, 32'h7, 33'h0);
    apb(1'b0, ADDR_HSC, 32'h0, {1'b0, 32'h5});
    waitc(40);
    apb(1'b0, ADDR_HSC, 32'h0, {1'b0, 32'h7});
    // every divide ratio, with every frequency code along the way
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, ADDR_HSC, {28'h0, 2'(k), 2'h1}, 33'h0);
      apb(1'b1, ADDR_SCC, {24'h0, 3'(k), 5'h0}, 33'h0);
      expect_mode(MODE_FAST);
      waitc(1400);
    end
    apb(1'b1, ADDR_SCC, 32'hE0, 33'h0);
    expect_mode(MODE_SLOW);
    waitc(1400);
    apb(1'b0, ADDR_STAT, 32'h0, {1'b0, 32'h171});
    for (int i = 0; i < 8; i++) begin
      idle = 2'(i);
      sel = i > 3 ? SEL_SUB : 3'($unsigned($random(seed)) % 7);
      apb(1'b1, ADDR_SCC, {24'h0, sel, 3'h0, idle}, 33'h0);
      expect_mode(sel == SEL_SUB ? MODE_SLOW : MODE_FAST);
      waitc(1400);
      // the two sleep passes see the watchdog off and then on
      watchdogEn <= (idle == 2'h0) ? 1'(i >> 2) : 1'($random(seed));
      cpuHalt <= 1'b1;
      @(posedge clk);
      cpuHalt <= 1'b0;
      expect_mode(halt_mode(idle));
      waitc(700);
      cpuHalt <= 1'b1;
      @(posedge clk);
      cpuHalt <= 1'b0;
      wakeUp <= 1'b1;
      @(posedge clk);
      wakeUp <= 1'b0;
      expect_mode(sel == SEL_SUB ? MODE_SLOW : MODE_FAST);
      waitc(20);
    end
    check("queues", 33'(busQ.size() + modeQ.size()), 33'h0);
    complete_run();
  end
endmodule
